/* File: core/pss_defs.svh */
// pump speed supervisor: register offsets, field positions, resets, timing counts
// assumes a 125 MHz pclk and 32-bit apb word addressing
// Summary of operation
// - self-test supply voltage before starting motor
// - boost at maximum speed, at most 5 minutes
// - current below threshold drops to nominal speed
// - no re-boost until stop and restart
// - stand-by setpoint defaults 66.7 percent, writable
// - stand-by speed confined to 30..100 percent
// - setpoint mode runs speed setpoint 30..170 percent
// - out-of-range setpoint clamps to nearest valid
// - setpoint mode wins over stand-by
// - set speed readable through two registers
// - led dark when supply inadequate
// - 1 Hz blink 10/50/90 percent by state
// - led steady at speed, 10 Hz on defect
// - temperature thresholds fixed, not writable
// - above 75 C limit to nominal, warn
// - below 72 C clear warning limit
// - above 85 C stop motor, latch malfunction
// - power cycle clears malfunction once cause gone
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PSS_CTRL_OFF 12'h000
`define PSS_STBY_SP_OFF 12'h004
`define PSS_SPD_SP_OFF 12'h008
`define PSS_SET_SPD_A_OFF 12'h00C
`define PSS_SET_SPD_B_OFF 12'h010
`define PSS_STATUS_OFF 12'h014
`define PSS_TEMP_OFF 12'h018

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define PSS_CTRL_ON_BIT 0
`define PSS_CTRL_STBY_BIT 1
`define PSS_CTRL_MODE_BIT 2
`define PSS_CTRL_ACK_BIT 3
`define PSS_CTRL_ERST_BIT 4

// ------------------------------------------------------------
// setpoints in tenths of a percent
// ------------------------------------------------------------
`define PSS_STBY_SP_RST 11'h29B
`define PSS_SPD_SP_RST 11'h3E8
`define PSS_NOMINAL 11'h3E8
`define PSS_STBY_MIN 11'h12C
`define PSS_STBY_MAX 11'h3E8
`define PSS_SPD_MIN 11'h12C
`define PSS_SPD_MAX 11'h6A4
`define PSS_BOOST_SPD 11'h6A4

// ------------------------------------------------------------
// temperatures in degrees celsius
// ------------------------------------------------------------
`define PSS_T_WARN 8'h4B
`define PSS_T_WARN_CLR 8'h48
`define PSS_T_FAULT 8'h55

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PSS_CLK_HZ 125000000
`define PSS_BOOST_MIN 5
`define PSS_BOOST_CYC (`PSS_BOOST_MIN * 60 * 64'h7735940)
`define PSS_SELFTEST_CYC 16
`define PSS_SLOW_HZ 1
`define PSS_FAST_HZ 10
`define PSS_LED_STEPS 100

`endif

/* File: core/pss_pkg.sv */
// pump speed supervisor types
// assumes pss_defs.svh supplies the numeric constants
package pss_pkg;
	typedef enum logic [5:0] {
		PSS_OFF = 6'b000001,
		PSS_TEST = 6'b000010,
		PSS_BOOST = 6'b000100,
		PSS_RUN = 6'b001000,
		PSS_FAULT = 6'b010000,
		PSS_DOWN = 6'b100000
	} pss_state_t;

	typedef struct packed {
		logic supply_ok;
		logic current_low;
		logic rotating;
		logic at_speed;
		logic [7:0] temp_c;
	} pss_sense_t;

	typedef struct packed {
		logic [6:0] duty;
		logic fast;
		logic dark;
	} pss_led_cfg_t;
endpackage : pss_pkg

/* File: core/pss_clamp.sv */
// setpoint clamp to a permitted window
// assumes all values in tenths of a percent
`timescale 1ns/1ps
module pss_clamp
	import pss_pkg::*;
#(
	parameter int W = 11
) (
	input wire logic [W-1:0] value,
	input wire logic [W-1:0] lo,
	input wire logic [W-1:0] hi,
	output logic [W-1:0] clamped
);
	// ------------------------------------------------------------
	// nearest valid value
	// ------------------------------------------------------------
	always_comb begin
		if (value < lo) begin
			clamped = lo;
		end else if (value > hi) begin
			clamped = hi;
		end else begin
			clamped = value;
		end
	end
endmodule : pss_clamp

/* File: core/pss_led.sv */
// status led pattern generator
// assumes one pclk; periods from the clock rate
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_led
	import pss_pkg::*;
#(
	parameter int CLK_HZ = `PSS_CLK_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire pss_led_cfg_t cfg,
	output logic led_q
);
	localparam int SLOW_DIV = CLK_HZ / (`PSS_SLOW_HZ * `PSS_LED_STEPS);
	localparam int FAST_DIV = CLK_HZ / (`PSS_FAST_HZ * `PSS_LED_STEPS);

	logic [31:0] div_q;
	logic [6:0] step_q;
	logic tick;

	// ------------------------------------------------------------
	// prescaler: one enable per hundredth of a period
	// ------------------------------------------------------------
	assign tick = (div_q >= 32'(cfg.fast ? FAST_DIV - 1 : SLOW_DIV - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 32'h0;
		end else if (tick) begin
			div_q <= 32'h0;
		end else begin
			div_q <= div_q + 32'h1;
		end
	end

	// step within the period; compare against the duty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_q <= 7'h0;
		end else if (tick) begin
			step_q <= (step_q == 7'(`PSS_LED_STEPS - 1)) ? 7'h0 : step_q + 7'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_q <= 1'b0;
		end else begin
			led_q <= !cfg.dark && (step_q < cfg.duty);
		end
	end
endmodule : pss_led

/* File: core/pss_top.sv */
// pump speed supervisor: start sequence, speed selection, temperature and led
// assumes sense inputs synchronous to pclk; registers over apb
// assumes the motor drive follows speed_cmd_q and reports back through sense
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_top
	import pss_pkg::*;
#(
	parameter longint BOOST_CYC = `PSS_BOOST_CYC,
	parameter int TEST_CYC = `PSS_SELFTEST_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pss_sense_t sense,
	output logic motor_on_q,
	output logic [10:0] speed_cmd_q,
	output logic warn_q,
	output logic fault_q,
	output logic led
);
	pss_state_t state_q, state_d;
	logic [4:0] ctrl_q;
	logic [10:0] stby_sp_q;
	logic [10:0] spd_sp_q;
	logic [63:0] boost_cnt_q;
	logic [31:0] test_cnt_q;
	logic ack_arm_q;
	logic ack_done_q;
	logic on_prev_q;
	logic [10:0] stby_clamped;
	logic [10:0] spd_clamped;
	logic [10:0] target;
	logic wr_en;
	logic ctrl_wr;
	logic erst_wr;
	logic addr_ok;
	logic over_fault;
	logic fault_gone;
	pss_led_cfg_t led_cfg;

	// ------------------------------------------------------------
	// apb access decode
	// ------------------------------------------------------------
	// zero wait states: access completes in its first access cycle
	// writes to the read-only words are dropped quietly; only an address
	// outside the map answers with an error
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign ctrl_wr = wr_en && paddr == `PSS_CTRL_OFF;
	always_comb begin
		case (paddr)
			`PSS_CTRL_OFF, `PSS_STBY_SP_OFF, `PSS_SPD_SP_OFF, `PSS_SET_SPD_A_OFF,
			`PSS_SET_SPD_B_OFF, `PSS_STATUS_OFF, `PSS_TEMP_OFF: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	// error is combinational and only high in the access phase
	assign pslverr = psel && penable && !addr_ok;

	// control bits: on, stand-by, setpoint mode, acknowledge, error reset
	// reset value 1 gives the automatic start once the reset lifts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 5'h01; // automatic start after power-up
		end else if (ctrl_wr) begin
			ctrl_q <= pwdata[4:0];
		end
	end

	// setpoints; temperature limits are constants with no write path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stby_sp_q <= `PSS_STBY_SP_RST;
			spd_sp_q <= `PSS_SPD_SP_RST;
		end else if (wr_en) begin
			if (paddr == `PSS_STBY_SP_OFF) begin
				stby_sp_q <= pwdata[10:0];
			end
			if (paddr == `PSS_SPD_SP_OFF) begin
				spd_sp_q <= pwdata[10:0];
			end
		end
	end

	// read mux registered so read data comes from flip-flops
	// loaded in the setup cycle so the word stands through the access cycle;
	// a read therefore shows state as it was one cycle before the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`PSS_CTRL_OFF: prdata <= {27'h0, ctrl_q};
				`PSS_STBY_SP_OFF: prdata <= {21'h0, stby_sp_q};
				`PSS_SPD_SP_OFF: prdata <= {21'h0, spd_sp_q};
				`PSS_SET_SPD_A_OFF: prdata <= {21'h0, speed_cmd_q};
				`PSS_SET_SPD_B_OFF: prdata <= {21'h0, target};
				`PSS_STATUS_OFF: prdata <= {26'h0, state_q};
				`PSS_TEMP_OFF: prdata <= {21'h0, fault_q, warn_q, motor_on_q, sense.temp_c};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// setpoint selection
	// ------------------------------------------------------------
	// stand-by window is 30 to 100 percent of nominal
	pss_clamp #(.W(11)) u_stby_clamp (
		.value(stby_sp_q),
		.lo(`PSS_STBY_MIN),
		.hi(`PSS_STBY_MAX),
		.clamped(stby_clamped)
	);

	// setpoint window is 30 to 170 percent of nominal
	pss_clamp #(.W(11)) u_spd_clamp (
		.value(spd_sp_q),
		.lo(`PSS_SPD_MIN),
		.hi(`PSS_SPD_MAX),
		.clamped(spd_clamped)
	);

	// setpoint mode is checked first so it wins over stand-by
	// with neither mode set the motor runs at nominal
	always_comb begin
		if (ctrl_q[`PSS_CTRL_MODE_BIT]) begin
			target = spd_clamped;
		end else if (ctrl_q[`PSS_CTRL_STBY_BIT]) begin
			target = stby_clamped;
		end else begin
			target = `PSS_NOMINAL;
		end
	end

	// ------------------------------------------------------------
	// temperature supervision with hysteresis
	// ------------------------------------------------------------
	// warning set above the warn level, cleared only below the lower one;
	// limits are macros with no write path, so software cannot move them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn_q <= 1'b0;
		end else if (sense.temp_c > `PSS_T_WARN) begin
			warn_q <= 1'b1;
		end else if (sense.temp_c < `PSS_T_WARN_CLR) begin
			warn_q <= 1'b0;
		end
	end

	// fault level has no hysteresis; clearing needs a restart or an ack
	assign over_fault = sense.temp_c > `PSS_T_FAULT;
	assign fault_gone = !over_fault;

	// error reset acts on the write itself, so a reset bit left set in the
	// control word cannot clear a later malfunction by itself
	assign erst_wr = ctrl_wr && pwdata[`PSS_CTRL_ERST_BIT];

	// acknowledge sequence: ack bit seen 0, then 1, then error reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_arm_q <= 1'b0;
			ack_done_q <= 1'b0;
		end else if (!fault_q) begin
			ack_arm_q <= 1'b0;
			ack_done_q <= 1'b0;
		end else begin
			if (!ctrl_q[`PSS_CTRL_ACK_BIT]) begin
				ack_arm_q <= 1'b1;
			end else if (ack_arm_q) begin
				ack_done_q <= 1'b1;
			end
		end
	end

	// malfunction latch; a new overtemperature beats any clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q <= 1'b0;
		end else if (over_fault) begin
			fault_q <= 1'b1;
		end else if (fault_gone && on_prev_q && !ctrl_q[`PSS_CTRL_ON_BIT]) begin
			fault_q <= 1'b0;
		end else if (ack_done_q && erst_wr) begin
			fault_q <= 1'b0;
		end
	end

	// previous on bit; its falling edge is the switch-off that clears a fault
	// reset low, so no false off edge follows reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_prev_q <= 1'b0;
		end else begin
			on_prev_q <= ctrl_q[`PSS_CTRL_ON_BIT];
		end
	end

	// ------------------------------------------------------------
	// run sequence
	// ------------------------------------------------------------
	// off -> self-test -> boost -> down -> run; a fault from boost or run
	// parks in fault until the latch clears, then the sequence starts over
	// from off, so a restart always passes the supply test again
	always_comb begin
		state_d = state_q;
		case (state_q)
			PSS_OFF: begin
				if (ctrl_q[`PSS_CTRL_ON_BIT] && !fault_q) begin
					state_d = PSS_TEST;
				end
			end
			PSS_TEST: begin
				// stay here until supply passes; never start on a bad supply
				if (!ctrl_q[`PSS_CTRL_ON_BIT]) begin
					state_d = PSS_OFF;
				end else if (test_cnt_q >= 32'(TEST_CYC - 1) && sense.supply_ok) begin
					state_d = PSS_BOOST;
				end
			end
			PSS_BOOST: begin
				if (fault_q) begin
					state_d = PSS_FAULT;
				end else if (!ctrl_q[`PSS_CTRL_ON_BIT]) begin
					state_d = PSS_OFF;
				end else if (sense.current_low || boost_cnt_q >= 64'(BOOST_CYC - 1)) begin
					state_d = PSS_DOWN;
				end
			end
			PSS_DOWN: begin
				// one cycle still at the boost command; the selected speed loads on the edge that enters run
				state_d = PSS_RUN;
			end
			PSS_RUN: begin
				// no direct path back to boost; the off path and the fault path both lead back through off
				if (fault_q) begin
					state_d = PSS_FAULT;
				end else if (!ctrl_q[`PSS_CTRL_ON_BIT]) begin
					state_d = PSS_OFF;
				end
			end
			PSS_FAULT: begin
				if (!fault_q) begin
					state_d = PSS_OFF;
				end
			end
			default: state_d = PSS_OFF;
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PSS_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// self-test and boost timers
	// self-test count saturates so a late supply still passes at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_cnt_q <= 32'h0;
		end else if (state_q != PSS_TEST) begin
			test_cnt_q <= 32'h0;
		end else if (test_cnt_q < 32'(TEST_CYC - 1)) begin
			test_cnt_q <= test_cnt_q + 32'h1;
		end
	end

	// 64 bits: five minutes of clock cycles does not fit in 32
	// boost time counts from the first boost cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boost_cnt_q <= 64'h0;
		end else if (state_q != PSS_BOOST) begin
			boost_cnt_q <= 64'h0;
		end else begin
			boost_cnt_q <= boost_cnt_q + 64'h1;
		end
	end

	// ------------------------------------------------------------
	// motor command
	// ------------------------------------------------------------
	// overtemperature is tested before the latch so the motor drops on the
	// same edge that the fault latches; a warning caps boost and setpoint alike
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motor_on_q <= 1'b0;
			speed_cmd_q <= 11'h0;
		end else if (over_fault || fault_q) begin
			motor_on_q <= 1'b0;
			speed_cmd_q <= 11'h0;
		end else if (state_q == PSS_BOOST) begin
			motor_on_q <= 1'b1;
			speed_cmd_q <= warn_q ? `PSS_NOMINAL : `PSS_BOOST_SPD;
		end else if (state_q == PSS_RUN || state_q == PSS_DOWN) begin
			motor_on_q <= 1'b1;
			speed_cmd_q <= (warn_q && target > `PSS_NOMINAL) ? `PSS_NOMINAL : target;
		end else begin
			motor_on_q <= 1'b0;
			speed_cmd_q <= 11'h0;
		end
	end

	// ------------------------------------------------------------
	// led pattern selection
	// ------------------------------------------------------------
	// a fault outranks every other pattern; a dark led outranks them all
	always_comb begin
		led_cfg.dark = !sense.supply_ok;
		led_cfg.fast = 1'b0;
		if (fault_q) begin
			led_cfg.fast = 1'b1;
			led_cfg.duty = 7'h32;
		end else if (!motor_on_q) begin
			led_cfg.duty = sense.rotating ? 7'h32 : 7'h0A;
		end else if (!sense.at_speed) begin
			led_cfg.duty = 7'h5A;
		end else begin
			led_cfg.duty = 7'h64;
		end
	end

	// blink timing runs from the full clock rate, so a slow period spans one second, a fast one 100 ms
	pss_led u_led (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(led_cfg),
		.led_q(led)
	);
endmodule : pss_top

/* File: tb/pss_chk.sv */
// pss_chk: port-level assertions for pss_top
// assumes binding onto pss_top; thresholds from pss_defs.svh
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_chk
	import pss_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire pss_sense_t sense,
	input wire logic motor_on_q,
	input wire logic [10:0] speed_cmd_q,
	input wire logic warn_q,
	input wire logic fault_q,
	input wire logic led
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// temperature
	// ----
	a_fault_set: assert property (sense.temp_c > `PSS_T_FAULT |=> fault_q)
		else $error("fault not latched");
	a_fault_stop: assert property (fault_q |-> !motor_on_q)
		else $error("motor runs in fault");
	a_warn_set: assert property (sense.temp_c > `PSS_T_WARN |=> warn_q || fault_q)
		else $error("warning not set");
	a_warn_clr: assert property (sense.temp_c < `PSS_T_WARN_CLR |=> !warn_q)
		else $error("warning not cleared");
	a_warn_hold: assert property (warn_q && sense.temp_c >= `PSS_T_WARN_CLR |=> warn_q)
		else $error("warning dropped early");
	// three cycles allowed for the speed register to follow the warning
	a_warn_limit: assert property (warn_q [*3] |-> speed_cmd_q <= `PSS_NOMINAL)
		else $error("speed not limited");
	// ----
	// speed, led, bus
	// ----
	a_speed_cap: assert property (speed_cmd_q <= `PSS_BOOST_SPD)
		else $error("speed above maximum");
	a_start_supply: assert property ($rose(motor_on_q) |-> $past(sense.supply_ok, 2))
		else $error("start without supply");
	a_led_dark: assert property ((!sense.supply_ok) [*4] |-> !led)
		else $error("led lit without supply");
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	a_unmapped: assert property (psel && penable && paddr > `PSS_TEMP_OFF |-> pslverr)
		else $error("no error on unmapped");
	c_fault: cover property ($rose(fault_q));
	c_warn: cover property ($rose(warn_q));
	c_stby: cover property (speed_cmd_q == `PSS_STBY_MIN);
endmodule : pss_chk

bind pss_top pss_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .sense(sense),
	.motor_on_q(motor_on_q), .speed_cmd_q(speed_cmd_q), .warn_q(warn_q),
	.fault_q(fault_q), .led(led));

/* File: tb/pss_ctl_model.sv */
// pss_ctl_model: the controller side, an apb master with one transfer task
// assumes pclk shared with the block; wait on pready is bounded
`timescale 1ns/1ps
module pss_ctl_model (
	input wire logic pclk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic hung
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		hung = 1'b0;
	end

	// request held until pready seen high; answer taken at that edge only
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		q = prdata;
		e = pslverr;
		hung = (n >= 64);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : pss_ctl_model

/* File: tb/pss_top_tb.sv */
// pss_top_tb: directed register and sense sequences for pss_top
// assumes pss_ctl_model as bus master and a short boost count
`timescale 1ns/1ps
module pss_top_tb
	import pss_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung, e;
	logic motor_on_q, warn_q, fault_q, led;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [10:0] speed_cmd_q;
	pss_sense_t sense;
	int error_cnt = 0;
	int compares = 0;

	// 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// boost shortened so a full timeout fits the run
	pss_top #(.BOOST_CYC(200), .TEST_CYC(16)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
		.motor_on_q(motor_on_q), .speed_cmd_q(speed_cmd_q), .warn_q(warn_q),
		.fault_q(fault_q), .led(led));
	pss_ctl_model ctl (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.hung(hung));

	task automatic summarize();
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk

	// a hung bus ends the run at once
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		ctl.xfer(1'b1, a, d, q, e);
		if (hung) begin
			error_cnt++;
			summarize();
		end
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		ctl.xfer(1'b0, a, 32'h0, q, e);
		if (hung) begin
			error_cnt++;
			summarize();
		end
		chk(q, x);
	endtask : rd

	task automatic sn(input logic [3:0] f, input logic [7:0] t);
		@(posedge pclk);
		sense <= {f, t};
	endtask : sn

	// sampling 1 ns after the edge keeps clear of the design's updates
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc

	task automatic wait_spd(input logic [10:0] v);
		int n;
		n = 0;
		#1;
		while (speed_cmd_q !== v && n < 400) begin
			cyc(1);
			n++;
		end
		chk({21'h0, speed_cmd_q}, {21'h0, v});
		if (n >= 400)
			summarize();
	endtask : wait_spd

	// ----
	// main sequence
	// ----
	initial begin
		presetn = 1'b0;
		sense = 12'h000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		cyc(40);
		chk({31'h0, motor_on_q}, 32'h0);
		rd(12'h000, 32'h1);
		rd(12'h004, 32'h29B);
		rd(12'h008, 32'h3E8);
		wr(12'h018, 32'hFF);
		rd(12'h018, 32'h0);
		sn(4'h8, 8'h14);
		wait_spd(11'h6A4);
		chk({31'h0, motor_on_q}, 32'h1);
		$display("end boot");
		sn(4'hC, 8'h14);
		wait_spd(11'h3E8);
		sn(4'h8, 8'h14);
		cyc(300);
		chk({21'h0, speed_cmd_q}, 32'h3E8);
		$display("end fallback");
		wr(12'h004, 32'hC8);
		wr(12'h000, 32'h3);
		wait_spd(11'h12C);
		rd(12'h010, 32'h12C);
		rd(12'h00C, 32'h12C);
		wr(12'h004, 32'h7D0);
		wait_spd(11'h3E8);
		$display("end standby");
		wr(12'h008, 32'h7D0);
		wr(12'h000, 32'h7);
		wait_spd(11'h6A4);
		wr(12'h008, 32'h64);
		wait_spd(11'h12C);
		wr(12'h008, 32'h5DC);
		wait_spd(11'h5DC);
		$display("end setpoint");
		sn(4'hB, 8'h50);
		wait_spd(11'h3E8);
		chk({31'h0, warn_q}, 32'h1);
		sn(4'hB, 8'h49);
		cyc(5);
		chk({31'h0, warn_q}, 32'h1);
		sn(4'hB, 8'h46);
		wait_spd(11'h5DC);
		chk({31'h0, warn_q}, 32'h0);
		$display("end warning");
		sn(4'hB, 8'h5A);
		cyc(3);
		chk({30'h0, fault_q, motor_on_q}, 32'h2);
		sn(4'h8, 8'h14);
		wr(12'h000, 32'h7);
		wr(12'h000, 32'hF);
		wr(12'h000, 32'h1F);
		cyc(3);
		chk({31'h0, fault_q}, 32'h0);
		sn(4'h8, 8'h5A);
		cyc(3);
		chk({31'h0, fault_q}, 32'h1);
		sn(4'h8, 8'h14);
		wr(12'h000, 32'h0);
		wr(12'h000, 32'h1);
		cyc(3);
		chk({31'h0, fault_q}, 32'h0);
		wait_spd(11'h6A4);
		wait_spd(11'h3E8);
		$display("end fault");
		rd(12'h100, 32'h0);
		chk({31'h0, e}, 32'h1);
		sn(4'h0, 8'h14);
		cyc(8);
		chk({31'h0, led}, 32'h0);
		$display("end bus and led");
		summarize();
	end
endmodule : pss_top_tb
